// *** lmc_ctrl.sv ***
// laser mode sequencer, video gating and register port
`timescale 1ns/1ps
module lmc_ctrl #(
    parameter int HOLD_LEN = lmc_pkg::HOLD_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        video_a_in,
    input  wire logic        video_b_in,
    input  wire logic        fixing_ready,
    input  wire logic        beam_detect_in_n,
    output logic             laser_mode_sel0,
    output logic             laser_mode_sel1,
    output logic             laser_mode_sel2,
    output logic             video_a_pos,
    output logic             video_a_neg,
    output logic             video_b_pos,
    output logic             video_b_neg,
    output logic             line_sync_out_n,
    output logic             scanner_run
);
    //==========================================================
    // declarations
    lmc_pkg::lmc_state_t state;
    logic [15:0] cnt;
    logic [15:0] reg_time;
    logic [15:0] line_time;
    logic        ctrl_print;
    logic        ctrl_test;
    logic        ctrl_discharge;
    logic        sync_seen;
    logic [15:0] line_count;
    logic [1:0]  fix_sync;
    logic        bd_pulse;
    logic        timer_done;
    logic        ctrl_wr;
    logic        stat_wr;
    logic        disch_taken;

    if (HOLD_LEN < 1 || HOLD_LEN > 65535) begin : g_bad_hold_len
        $error("lmc_ctrl: HOLD_LEN out of range");
    end

    //==========================================================
    // decoding shared by mode outputs and video gating
    function automatic logic [2:0] lmc_mode_of(input lmc_pkg::lmc_state_t s);
        case (s)
            lmc_pkg::ST_DISCHARGE: lmc_mode_of = lmc_pkg::MODE_DISCHARGE;
            lmc_pkg::ST_INIT_A,
            lmc_pkg::ST_LINE_A:    lmc_mode_of = lmc_pkg::MODE_REG_A;
            lmc_pkg::ST_INIT_B,
            lmc_pkg::ST_LINE_B:    lmc_mode_of = lmc_pkg::MODE_REG_B;
            lmc_pkg::ST_DATA:      lmc_mode_of = lmc_pkg::MODE_DATA;
            lmc_pkg::ST_TEST:      lmc_mode_of = lmc_pkg::MODE_FORCE_ON;
            default:               lmc_mode_of = lmc_pkg::MODE_FORCE_OFF;
        endcase
    endfunction : lmc_mode_of

    function automatic logic lmc_scanning(input lmc_pkg::lmc_state_t s);
        case (s)
            lmc_pkg::ST_IDLE,
            lmc_pkg::ST_DISCHARGE,
            lmc_pkg::ST_TEST: lmc_scanning = 1'b0;
            default:          lmc_scanning = 1'b1;
        endcase
    endfunction : lmc_scanning

    assign timer_done  = (cnt == 16'h0000);
    assign ctrl_wr     = wr && (addr == lmc_pkg::ADDR_CTRL);
    assign stat_wr     = wr && (addr == lmc_pkg::ADDR_STATUS);
    assign disch_taken = (state == lmc_pkg::ST_IDLE) && ctrl_discharge;

    //==========================================================
    // line sync from the beam detector
    lmc_line_sync #(
        .SYNC_W          (lmc_pkg::SYNC_CYCLES)
    ) u_sync (
        .clk             (clk),
        .rst             (rst),
        .beam_detect_in_n(beam_detect_in_n),
        .line_sync_out_n (line_sync_out_n),
        .bd_pulse        (bd_pulse)
    );

    // fixing temperature flag comes from another board
    always_ff @(posedge clk) begin
        if (rst) begin
            fix_sync <= 2'h0;
        end else begin
            fix_sync <= {fix_sync[0], fixing_ready};
        end
    end

    //==========================================================
    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= lmc_pkg::ST_IDLE;
            cnt   <= 16'h0000;
        end else begin
            if (!timer_done) begin
                cnt <= cnt - 16'h0001;
            end
            case (state)
                lmc_pkg::ST_IDLE: begin
                    if (ctrl_discharge) begin
                        state <= lmc_pkg::ST_DISCHARGE;
                        cnt   <= reg_time;
                    end else if (ctrl_print) begin
                        state <= lmc_pkg::ST_INIT_A;
                        cnt   <= reg_time;
                    end else if (ctrl_test) begin
                        state <= lmc_pkg::ST_TEST;
                    end
                end
                lmc_pkg::ST_DISCHARGE: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_IDLE;
                    end
                end
                lmc_pkg::ST_INIT_A: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_INIT_HOLD_A;
                        cnt   <= 16'(HOLD_LEN);
                    end
                end
                lmc_pkg::ST_INIT_HOLD_A: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_INIT_B;
                        cnt   <= reg_time;
                    end
                end
                lmc_pkg::ST_INIT_B: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_INIT_HOLD_B;
                        cnt   <= 16'(HOLD_LEN);
                    end
                end
                lmc_pkg::ST_INIT_HOLD_B: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_WAIT_FIX;
                    end
                end
                lmc_pkg::ST_WAIT_FIX: begin
                    // initial rotation ends at fixing temperature, or in idle when print is cleared
                    if (!ctrl_print) begin
                        state <= lmc_pkg::ST_IDLE;
                    end else if (fix_sync[1]) begin
                        state <= lmc_pkg::ST_LINE_A;
                        cnt   <= reg_time;
                    end
                end
                lmc_pkg::ST_LINE_A: begin
                    // regulation light doubles as the unblanking beam
                    if (timer_done) begin
                        state <= lmc_pkg::ST_LINE_HOLD_A;
                        cnt   <= 16'(HOLD_LEN);
                    end
                end
                lmc_pkg::ST_LINE_HOLD_A: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_LINE_B;
                        cnt   <= reg_time;
                    end
                end
                lmc_pkg::ST_LINE_B: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_LINE_HOLD_B;
                        cnt   <= 16'(HOLD_LEN);
                    end
                end
                lmc_pkg::ST_LINE_HOLD_B: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_DATA;
                        cnt   <= line_time;
                    end
                end
                lmc_pkg::ST_DATA: begin
                    if (timer_done) begin
                        state <= lmc_pkg::ST_MASK;
                        cnt   <= 16'(HOLD_LEN);
                    end
                end
                lmc_pkg::ST_MASK: begin
                    // a cleared print bit ends the job only between lines
                    if (timer_done) begin
                        if (ctrl_print) begin
                            state <= lmc_pkg::ST_LINE_A;
                            cnt   <= reg_time;
                        end else begin
                            state <= lmc_pkg::ST_IDLE;
                        end
                    end
                end
                lmc_pkg::ST_TEST: begin
                    if (!ctrl_test) begin
                        state <= lmc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= lmc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    //==========================================================
    // pin outputs, all registered so mode lines only move on edges
    always_ff @(posedge clk) begin
        if (rst) begin
            {laser_mode_sel2, laser_mode_sel1, laser_mode_sel0}
                <= lmc_pkg::MODE_FORCE_OFF;
            scanner_run <= 1'b0;
        end else begin
            {laser_mode_sel2, laser_mode_sel1, laser_mode_sel0}
                <= lmc_mode_of(state);
            scanner_run <= lmc_scanning(state);
        end
    end

    // video pairs idle at logic low outside data mode
    always_ff @(posedge clk) begin
        if (rst) begin
            video_a_pos <= 1'b0;
            video_a_neg <= 1'b1;
            video_b_pos <= 1'b0;
            video_b_neg <= 1'b1;
        end else if (lmc_mode_of(state) == lmc_pkg::MODE_DATA) begin
            video_a_pos <= video_a_in;
            video_a_neg <= ~video_a_in;
            video_b_pos <= video_b_in;
            video_b_neg <= ~video_b_in;
        end else begin
            video_a_pos <= 1'b0;
            video_a_neg <= 1'b1;
            video_b_pos <= 1'b0;
            video_b_neg <= 1'b1;
        end
    end

    //==========================================================
    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_print     <= 1'b0;
            ctrl_test      <= 1'b0;
            ctrl_discharge <= 1'b0;
            reg_time       <= lmc_pkg::REG_TIME_RESET;
            line_time      <= lmc_pkg::LINE_TIME_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_print <= wdata[lmc_pkg::CTRL_PRINT_BIT];
                ctrl_test  <= wdata[lmc_pkg::CTRL_TEST_BIT];
            end
            // software request wins over the hardware self-clear
            if (ctrl_wr && wdata[lmc_pkg::CTRL_DISCHARGE_BIT]) begin
                ctrl_discharge <= 1'b1;
            end else if (disch_taken) begin
                ctrl_discharge <= 1'b0;
            end
            if (wr && addr == lmc_pkg::ADDR_REG_TIME) begin
                reg_time <= wdata[15:0];
            end
            if (wr && addr == lmc_pkg::ADDR_LINE_TIME) begin
                line_time <= wdata[15:0];
            end
        end
    end

    // sync status: set by hardware, write-one-to-clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_seen  <= 1'b0;
            line_count <= 16'h0000;
        end else begin
            if (bd_pulse) begin
                sync_seen  <= 1'b1;
                line_count <= line_count + 16'h0001;
            end else if (stat_wr && wdata[lmc_pkg::STAT_SYNC_SEEN_BIT]) begin
                sync_seen <= 1'b0;
            end
        end
    end

    //==========================================================
    // register reads, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                lmc_pkg::ADDR_CTRL: begin
                    rdata <= {29'h0000_0000, ctrl_discharge, ctrl_test, ctrl_print};
                end
                lmc_pkg::ADDR_REG_TIME: begin
                    rdata <= {16'h0000, reg_time};
                end
                lmc_pkg::ADDR_LINE_TIME: begin
                    rdata <= {16'h0000, line_time};
                end
                lmc_pkg::ADDR_STATUS: begin
                    rdata <= {line_count, 8'h00, state, 1'b0, scanner_run,
                              fix_sync[1], sync_seen};
                end
                default: begin
                    rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule : lmc_ctrl

// *** lmc_line_sync.sv ***
// package of constants and the beam-detect to line-sync converter
//==========================================================
package lmc_pkg;
    //==========================================================
    // mode codes, bit order {sel2, sel1, sel0}
    localparam logic [2:0] MODE_DISCHARGE = 3'h0;
    localparam logic [2:0] MODE_DATA      = 3'h7;
    localparam logic [2:0] MODE_REG_A     = 3'h2;
    localparam logic [2:0] MODE_REG_B     = 3'h1;
    localparam logic [2:0] MODE_FORCE_ON  = 3'h4;
    localparam logic [2:0] MODE_FORCE_OFF = 3'h3;
    //==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_REG_TIME  = 8'h04;
    localparam logic [7:0] ADDR_LINE_TIME = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam int CTRL_PRINT_BIT     = 0;
    localparam int CTRL_TEST_BIT      = 1;
    localparam int CTRL_DISCHARGE_BIT = 2;
    localparam int STAT_SYNC_SEEN_BIT = 0;
    localparam int STAT_FIX_READY_BIT = 1;
    localparam int STAT_SCAN_RUN_BIT  = 2;
    localparam int STAT_STATE_LSB     = 4;
    localparam int STAT_COUNT_LSB     = 16;
    localparam logic [15:0] REG_TIME_RESET  = 16'h0100;
    localparam logic [15:0] LINE_TIME_RESET = 16'h1000;
    //==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HOLD_NS       = 200;
    localparam int SYNC_PULSE_NS = 100;
    localparam int HOLD_CYCLES   = (HOLD_NS * 1000) / CLK_PERIOD_PS;
    localparam int SYNC_CYCLES   = (SYNC_PULSE_NS * 1000) / CLK_PERIOD_PS;
    //==========================================================
    typedef enum logic [3:0] {
        ST_IDLE        = 4'b0000,
        ST_DISCHARGE   = 4'b0001,
        ST_INIT_A      = 4'b0010,
        ST_INIT_HOLD_A = 4'b0011,
        ST_INIT_B      = 4'b0100,
        ST_INIT_HOLD_B = 4'b0101,
        ST_WAIT_FIX    = 4'b0110,
        ST_LINE_A      = 4'b0111,
        ST_LINE_HOLD_A = 4'b1000,
        ST_LINE_B      = 4'b1001,
        ST_LINE_HOLD_B = 4'b1010,
        ST_DATA        = 4'b1011,
        ST_MASK        = 4'b1100,
        ST_TEST        = 4'b1101
    } lmc_state_t;
endpackage : lmc_pkg

`timescale 1ns/1ps
module lmc_line_sync #(
    parameter int SYNC_W = lmc_pkg::SYNC_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic beam_detect_in_n,
    output logic      line_sync_out_n,
    output logic      bd_pulse
);
    logic [1:0] bd_sync;
    logic       bd_last;
    logic [7:0] width_cnt;

    if (SYNC_W < 1 || SYNC_W > 255) begin : g_bad_sync_w
        $error("lmc_line_sync: SYNC_W out of range");
    end

    // two stages before any logic looks at the pin
    always_ff @(posedge clk) begin
        if (rst) begin
            bd_sync <= 2'h3;
            bd_last <= 1'b1;
        end else begin
            bd_sync <= {bd_sync[0], beam_detect_in_n};
            bd_last <= bd_sync[1];
        end
    end

    // fixed-width low pulse per falling beam-detect edge
    always_ff @(posedge clk) begin
        if (rst) begin
            width_cnt       <= 8'h00;
            line_sync_out_n <= 1'b1;
            bd_pulse        <= 1'b0;
        end else begin
            bd_pulse <= bd_last & ~bd_sync[1];
            if (bd_last & ~bd_sync[1]) begin
                width_cnt       <= 8'(SYNC_W);
                line_sync_out_n <= 1'b0;
            end else if (width_cnt > 8'h01) begin
                width_cnt <= width_cnt - 8'h01;
            end else begin
                width_cnt       <= 8'h00;
                line_sync_out_n <= 1'b1;
            end
        end
    end
endmodule : lmc_line_sync

// *** lmc_driver_model.sv ***
// behavioural laser driver and video controller facing lmc_ctrl
`timescale 1ns/1ps
module lmc_driver_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic laser_mode_sel0,
    input  wire logic laser_mode_sel1,
    input  wire logic laser_mode_sel2,
    input  wire logic video_a_pos,
    input  wire logic video_a_neg,
    input  wire logic video_b_pos,
    input  wire logic video_b_neg,
    input  wire logic line_sync_out_n,
    output logic      diode_a,
    output logic      diode_b,
    output logic      cap_a_held,
    output logic      cap_b_held,
    output logic      beam_detect_in_n,
    output logic      video_a_in,
    output logic      video_b_in
);
    logic [2:0] mode;
    logic [2:0] prev_mode;
    logic [2:0] bd_cnt;
    logic [7:0] lfsr;
    logic       sending;
    logic       prev_sync_n;
    assign mode = {laser_mode_sel2, laser_mode_sel1, laser_mode_sel0};
    //==========================================================
    // mode decode of the driver
    always_comb begin
        diode_a = (mode == 3'h2) || (mode == 3'h4);
        diode_b = (mode == 3'h1) || (mode == 3'h4);
        if (mode == 3'h7) begin
            diode_a = video_a_pos & ~video_a_neg;
            diode_b = video_b_pos & ~video_b_neg;
        end
    end
    // discharge and force-off keep both diodes dark
    always_ff @(posedge clk) begin
        prev_mode <= mode;
        if (rst || mode == 3'h0) begin
            cap_a_held <= 1'b0;
            cap_b_held <= 1'b0;
        end else if (mode == 3'h3) begin
            if (prev_mode == 3'h2) cap_a_held <= 1'b1;
            if (prev_mode == 3'h1) cap_b_held <= 1'b1;
        end
    end
    //==========================================================
    // beam detector: light reaches it only on entry to diode A regulation
    always_ff @(posedge clk) begin
        if (rst) bd_cnt <= 3'h0;
        else if (mode == 3'h2 && prev_mode != 3'h2) bd_cnt <= 3'h4;
        else if (bd_cnt != 3'h0) bd_cnt <= bd_cnt - 3'h1;
    end
    assign beam_detect_in_n = (bd_cnt == 3'h0);
    //==========================================================
    // video controller: no image bits before the first line sync
    always_ff @(posedge clk) begin
        prev_sync_n <= line_sync_out_n;
        if (rst) begin
            sending    <= 1'b0;
            lfsr       <= 8'hA5;
            video_a_in <= 1'b0;
            video_b_in <= 1'b0;
        end else begin
            if (prev_sync_n && !line_sync_out_n) sending <= 1'b1;
            lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            video_a_in <= sending & lfsr[0];
            video_b_in <= sending & lfsr[3];
        end
    end
endmodule : lmc_driver_model

// *** lmc_ctrl_sva.sv ***
// assertion checker for lmc_ctrl, bound at its ports
`timescale 1ns/1ps
module lmc_ctrl_sva #(
    parameter int HOLD_LEN = lmc_pkg::HOLD_CYCLES
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic [31:0] rdata,
    input wire logic        video_a_in,
    input wire logic        video_b_in,
    input wire logic        beam_detect_in_n,
    input wire logic        laser_mode_sel0,
    input wire logic        laser_mode_sel1,
    input wire logic        laser_mode_sel2,
    input wire logic        video_a_pos,
    input wire logic        video_a_neg,
    input wire logic        video_b_pos,
    input wire logic        video_b_neg,
    input wire logic        line_sync_out_n,
    input wire logic        scanner_run
);
    logic [2:0]  mode;
    logic [2:0]  prev_mode;
    logic [15:0] run_len;
    logic [7:0]  sync_low;
    assign mode = {laser_mode_sel2, laser_mode_sel1, laser_mode_sel0};
    //==========================================================
    // run lengths up to the previous sample, the current one not counted
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_mode <= 3'h3;
            run_len   <= 16'h0000;
            sync_low  <= 8'h00;
        end else begin
            prev_mode <= mode;
            run_len   <= (mode != prev_mode) ? 16'h0001 : run_len + 16'h0001;
            sync_low  <= line_sync_out_n ? 8'h00 : sync_low + 8'h01;
        end
    end
    //==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bd_fall;
        $fell(beam_detect_in_n);
    endsequence
    sequence s_print_idle;
        wr && addr == lmc_pkg::ADDR_CTRL && wdata[2:0] == 3'h1 && !scanner_run && mode == 3'h3;
    endsequence
    a_reset_values: assert property ($past(rst) |-> mode == 3'h3 && line_sync_out_n
        && !scanner_run && rdata == 32'h0) else $error("outputs wrong after reset");
    a_print_reg_a: assert property (s_print_idle |-> ##3 mode == 3'h2)
        else $error("print did not start diode A regulation");
    a_reg_a_off: assert property (prev_mode == 3'h2 && mode != 3'h2 |-> mode == 3'h3)
        else $error("diode A regulation not followed by force off");
    a_reg_b_off: assert property (prev_mode == 3'h1 && mode != 3'h1 |-> mode == 3'h3)
        else $error("diode B regulation not followed by force off");
    a_hold_length: assert property (mode == 3'h1 && prev_mode == 3'h3
        |-> run_len == HOLD_LEN + 1) else $error("hold before diode B has wrong length");
    a_data_follow: assert property (mode == 3'h7 |-> video_a_pos == $past(video_a_in)
        && video_a_neg != $past(video_a_in) && video_b_pos == $past(video_b_in)
        && video_b_neg != $past(video_b_in)) else $error("video pairs do not follow data");
    a_video_off: assert property (mode != 3'h7 |-> !video_a_pos && video_a_neg
        && !video_b_pos && video_b_neg) else $error("video pairs active outside data mode");
    a_sync_delay: assert property (s_bd_fall |-> ##[3:4] $fell(line_sync_out_n))
        else $error("line sync did not follow beam detect");
    a_sync_width: assert property ($rose(line_sync_out_n)
        |-> sync_low == lmc_pkg::SYNC_CYCLES) else $error("line sync pulse has wrong width");
    a_scanner_modes: assert property (mode != 3'h3
        |-> scanner_run == (mode inside {3'h1, 3'h2, 3'h7})) else $error("scanner_run wrong");
endmodule : lmc_ctrl_sva

bind lmc_ctrl lmc_ctrl_sva #(.HOLD_LEN(HOLD_LEN)) u_sva (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rdata(rdata), .video_a_in(video_a_in), .video_b_in(video_b_in),
    .beam_detect_in_n(beam_detect_in_n), .laser_mode_sel0(laser_mode_sel0),
    .laser_mode_sel1(laser_mode_sel1), .laser_mode_sel2(laser_mode_sel2),
    .video_a_pos(video_a_pos), .video_a_neg(video_a_neg), .video_b_pos(video_b_pos),
    .video_b_neg(video_b_neg), .line_sync_out_n(line_sync_out_n), .scanner_run(scanner_run));

// *** lmc_tb.sv ***
// self-checking bench for lmc_ctrl with the driver model
`timescale 1ns/1ps
module tb;
    localparam int HOLD = 4;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fixing_ready = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic        sel0, sel1, sel2, vap, van, vbp, vbn, line_sync_out_n, scanner_run;
    logic        video_a_in, video_b_in, beam_detect_in_n, diode_a, diode_b, cap_a, cap_b;
    logic [15:0] reg_t, line_t;
    logic [2:0]  mode;
    int          fail_count = 0, samples_checked = 0, sync_pulses = 0, guard;
    assign mode = {sel2, sel1, sel0};
    always #2.5 clk = ~clk;
    always @(negedge line_sync_out_n) if (rst === 1'b0) sync_pulses++;
    lmc_ctrl #(.HOLD_LEN(HOLD)) u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .video_a_in(video_a_in), .video_b_in(video_b_in),
        .fixing_ready(fixing_ready), .beam_detect_in_n(beam_detect_in_n),
        .laser_mode_sel0(sel0), .laser_mode_sel1(sel1), .laser_mode_sel2(sel2),
        .video_a_pos(vap), .video_a_neg(van), .video_b_pos(vbp), .video_b_neg(vbn),
        .line_sync_out_n(line_sync_out_n), .scanner_run(scanner_run));
    lmc_driver_model u_model (.clk(clk), .rst(rst), .laser_mode_sel0(sel0),
        .laser_mode_sel1(sel1), .laser_mode_sel2(sel2), .video_a_pos(vap), .video_a_neg(van),
        .video_b_pos(vbp), .video_b_neg(vbn), .line_sync_out_n(line_sync_out_n),
        .diode_a(diode_a), .diode_b(diode_b), .cap_a_held(cap_a), .cap_b_held(cap_b),
        .beam_detect_in_n(beam_detect_in_n), .video_a_in(video_a_in), .video_b_in(video_b_in));
    //==========================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_mode(input logic [2:0] code);
        int n;
        n = 0;
        #1;
        while (mode !== code && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("mode reached", code, mode);
    endtask : wait_mode
    // counts the samples that show one mode code
    task automatic run(input logic [2:0] code, input int len);
        int cnt;
        cnt = 0;
        wait_mode(code);
        while (mode === code && cnt < 20000) begin
            cnt++;
            @(posedge clk);
            #1;
        end
        if (len != 0) check("mode run length", len, cnt);
    endtask : run
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    //==========================================================
    // watchdog: the whole sequence needs a few hundred cycles, the limit is 40000
    initial begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        void'($urandom(28523));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("reset outputs", 32'h16, {vap, van, vbp, vbn, line_sync_out_n, scanner_run});
        check("reset mode", 3'h3, mode);
        rd_reg(lmc_pkg::ADDR_REG_TIME, rv);
        check("reg_time reset", {16'h0000, lmc_pkg::REG_TIME_RESET}, rv);
        rd_reg(lmc_pkg::ADDR_LINE_TIME, rv);
        check("line_time reset", {16'h0000, lmc_pkg::LINE_TIME_RESET}, rv);
        wr_reg(8'h10, 32'hFFFF_FFFF);
        rd_reg(8'h10, rv);
        check("unmapped read", 32'h0, rv);
        reg_t  = 16'h0014 + 16'($urandom_range(20));
        line_t = 16'h001E + 16'($urandom_range(30));
        wr_reg(lmc_pkg::ADDR_REG_TIME, {16'h0000, reg_t});
        wr_reg(lmc_pkg::ADDR_LINE_TIME, {16'h0000, line_t});
        rd_reg(lmc_pkg::ADDR_REG_TIME, rv);
        check("reg_time", {16'h0000, reg_t}, rv);
        $display("test reset and registers done");
        wr_reg(lmc_pkg::ADDR_CTRL, 32'h0000_0002);
        wait_mode(3'h4);
        check("forced diodes", 2'h3, {diode_a, diode_b});
        check("scanner in test", 1'b0, scanner_run);
        wr_reg(lmc_pkg::ADDR_CTRL, 32'h0);
        wait_mode(3'h3);
        $display("test force on done");
        wr_reg(lmc_pkg::ADDR_CTRL, 32'h0000_0001);
        run(3'h2, reg_t + 1);
        run(3'h3, HOLD + 1);
        run(3'h1, reg_t + 1);
        repeat (HOLD + 40 + $urandom_range(40)) @(posedge clk);
        #1;
        check("fixing wait", 3'h3, mode);
        check("scanner start", 1'b1, scanner_run);
        check("caps held", 2'h3, {cap_a, cap_b});
        @(posedge clk) fixing_ready <= 1'b1;
        for (int line = 0; line < 2; line++) begin
            run(3'h2, reg_t + 1);
            run(3'h3, HOLD + 1);
            fork
                run(3'h1, reg_t + 1);
                wr_reg(lmc_pkg::ADDR_CTRL, {31'h0, line == 0});
            join
            run(3'h3, HOLD + 1);
            run(3'h7, line_t + 1);
        end
        guard = 0;
        while (scanner_run !== 1'b0 && guard < 20000) begin
            @(posedge clk);
            #1;
            guard++;
        end
        check("job end", 4'h3, {scanner_run, mode});
        check("line sync count", 3, sync_pulses);
        rd_reg(lmc_pkg::ADDR_STATUS, rv);
        check("sync seen", 32'h1, rv & 32'h5);
        wr_reg(lmc_pkg::ADDR_STATUS, 32'h1);
        rd_reg(lmc_pkg::ADDR_STATUS, rv);
        check("sync cleared", 32'h0, rv & 32'h5);
        $display("test print job done");
        wr_reg(lmc_pkg::ADDR_CTRL, 32'h0000_0004);
        wait_mode(3'h0);
        wait_mode(3'h3);
        check("caps emptied", 2'h0, {cap_a, cap_b});
        rd_reg(lmc_pkg::ADDR_CTRL, rv);
        check("discharge self clear", 32'h0, rv);
        $display("test discharge done");
        conclude();
    end
endmodule : tb
